// File: hdl/abs_pkg.sv
package abs_pkg;
   // Register byte addresses (printed offset 0x0B is not a multiple of four: index times four)
   localparam logic [7:0] ABS_IDX_STATUS = 8'h0B;
   localparam logic [7:0] ABS_IDX_SETUP_ONE = 8'h0C;
   localparam logic [7:0] ABS_IDX_SETUP_TWO = 8'h0D;
   localparam logic [7:0] ABS_IDX_SETUP_IRQ = 8'h0E;
   localparam logic [9:0] ABS_ADDR_STATUS = {ABS_IDX_STATUS, 2'b00};
   localparam logic [9:0] ABS_ADDR_SETUP_ONE = {ABS_IDX_SETUP_ONE, 2'b00};
   localparam logic [9:0] ABS_ADDR_SETUP_TWO = {ABS_IDX_SETUP_TWO, 2'b00};
   localparam logic [9:0] ABS_ADDR_SETUP_IRQ = {ABS_IDX_SETUP_IRQ, 2'b00};
   // Status field positions
   localparam int ABS_WMRK_BIT = 7;
   localparam int ABS_OVF_BIT = 6;
   localparam int ABS_CNT_MSB = 5;
   // Setup one: mode field; setup two: flush bit and watermark level
   localparam int ABS_MODE_LSB = 0;
   localparam int ABS_FLUSH_BIT = 7;
   localparam int ABS_LEVEL_MSB = 5;
   // Irq setup: enable and pin select
   localparam int ABS_IRQ_EN_BIT = 0;
   localparam int ABS_IRQ_SEL_BIT = 1;
   localparam logic [1:0] ABS_MODE_OFF = 2'b00;
   localparam logic [7:0] ABS_STATUS_RST = 8'h00;
   localparam logic [5:0] ABS_DEPTH = 6'h20;
   localparam logic [1:0] ABS_RESP_OKAY = 2'b00;
   localparam logic [1:0] ABS_RESP_SLVERR = 2'b10;
endpackage

// File: hdl/abs_status_flags.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module abs_status_flags #(
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sampleWrite,
   input wire logic sampleRead,
   output logic irqPinOne,
   output logic irqPinTwo,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import abs_pkg::*;

   // Refuse any depth other than 32, at elaboration
   if (DEPTH != 32)
   begin : g_depthCheck
      $error("abs_status_flags: DEPTH must be 32");
   end

   logic [1:0] mode_q;
   logic [5:0] level_q;
   logic irqEn_q;
   logic irqSel_q;
   logic [5:0] count_q;
   logic [5:0] count_d;
   logic wmrk_q;
   logic ovf_q;
   logic [9:0] awAddr_q;
   logic awHave_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic wHave_q;

   // Write channel capture in either order; response after both
   wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
   wire hitOne = awAddr_q == ABS_ADDR_SETUP_ONE;
   wire hitTwo = awAddr_q == ABS_ADDR_SETUP_TWO;
   wire hitIrq = awAddr_q == ABS_ADDR_SETUP_IRQ;
   wire hitStat = awAddr_q == ABS_ADDR_STATUS;
   wire wMapped = hitOne || hitTwo || hitIrq || hitStat;
   wire lane0 = wStrb_q[0];
   wire modeWr = doWrite && hitOne && lane0;
   wire [1:0] newMode = wData_q[ABS_MODE_LSB +: 2];
   wire disableNow = modeWr && (newMode == ABS_MODE_OFF);
   wire flushNow = doWrite && hitTwo && lane0 && wData_q[ABS_FLUSH_BIT];
   wire bufOn = mode_q != ABS_MODE_OFF;
   wire clearAll = disableNow || flushNow || !bufOn;

   // Occupancy tracking; overflow when a sample arrives on a full buffer and no read is taken in the same cycle
   wire full = count_q == ABS_DEPTH;
   wire doRead = sampleRead && (count_q != 6'h00);
   wire doPut = sampleWrite && bufOn;
   wire ovfEvent = doPut && full && !doRead;
   always_comb
   begin
      count_d = count_q;
      if (clearAll)
         count_d = 6'h00;
      else if (doPut && !doRead && !full)
         count_d = count_q + 6'h01;
      else if (doRead && !doPut)
         count_d = count_q - 6'h01;
   end

   // Status as seen by software; zero while disabled
   wire [7:0] statusView = bufOn ? {wmrk_q, ovf_q, count_q} : ABS_STATUS_RST;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count_q <= 6'h00;
         wmrk_q <= 1'b0;
         ovf_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         wmrk_q <= !clearAll && (count_d >= level_q);
         if (clearAll || doRead)
            ovf_q <= ovfEvent;
         else if (ovfEvent)
            ovf_q <= 1'b1;
      end
   end

   // Control registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mode_q <= ABS_MODE_OFF;
         level_q <= 6'h00;
         irqEn_q <= 1'b0;
         irqSel_q <= 1'b0;
      end
      else
      begin
         if (modeWr)
            mode_q <= newMode;
         if (doWrite && hitTwo && lane0)
            level_q <= wData_q[ABS_LEVEL_MSB:0];
         if (doWrite && hitIrq && lane0)
         begin
            irqEn_q <= wData_q[ABS_IRQ_EN_BIT];
            irqSel_q <= wData_q[ABS_IRQ_SEL_BIT];
         end
      end
   end

   // Interrupt routing to one of two pins
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irqPinOne <= 1'b0;
         irqPinTwo <= 1'b0;
      end
      else
      begin
         irqPinOne <= irqEn_q && !irqSel_q && wmrk_q && bufOn;
         irqPinTwo <= irqEn_q && irqSel_q && wmrk_q && bufOn;
      end
   end

   // AXI write path
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 10'h000;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ABS_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !awHave_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHave_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr[9:0];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wMapped && !hitStat) ? ABS_RESP_OKAY : ABS_RESP_SLVERR;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI read path
   wire [9:0] rAddr = s_axi_araddr[9:0];
   wire rHitStat = rAddr == ABS_ADDR_STATUS;
   wire rHitOne = rAddr == ABS_ADDR_SETUP_ONE;
   wire rHitTwo = rAddr == ABS_ADDR_SETUP_TWO;
   wire rHitIrq = rAddr == ABS_ADDR_SETUP_IRQ;
   wire rMapped = rHitStat || rHitOne || rHitTwo || rHitIrq;
   wire [7:0] rByte = rHitStat ? statusView :
                      rHitOne ? {6'h00, mode_q} :
                      rHitTwo ? {2'b00, level_q} :
                      rHitIrq ? {6'h00, irqSel_q, irqEn_q} : 8'h00;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= ABS_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rByte};
            s_axi_rresp <= rMapped ? ABS_RESP_OKAY : ABS_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// File: sim/abs_status_flags_sva.sv
`timescale 1ns/10ps
module abs_status_flags_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic irqPinOne,
   input wire logic irqPinTwo,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Address and write handshakes
   sequence rdHs;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wrHs;
      s_axi_awvalid && s_axi_awready && s_axi_wready;
   endsequence
   // Bus answers and the watermark routing
   a_irq_one_pin: assert property (!(irqPinOne && irqPinTwo)) else $error("both irq pins high");
   a_read_answer: assert property (rdHs |=> s_axi_rvalid) else $error("no read answer");
   a_write_answer: assert property (wrHs |=> ##1 s_axi_bvalid) else $error("no write answer");
   a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
   a_arready_once: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
   a_awready_once: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
   a_no_stray_read: assert property (!s_axi_rvalid && !rdHs |=> !s_axi_rvalid) else $error("stray rvalid");
endmodule
bind abs_status_flags abs_status_flags_sva chk (.clk, .rst, .irqPinOne, .irqPinTwo, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready);

// File: sim/abs_sample_src.sv
`timescale 1ns/10ps
module abs_sample_src (
   input wire logic clk,
   output logic sampleWrite,
   output logic sampleRead
);
   // Idle at time zero
   initial
   begin
      sampleWrite = 1'b0;
      sampleRead = 1'b0;
   end
   // One triplet stored or read out per clock for n clocks
   task automatic push(input int n, input logic rd);
      @(posedge clk);
      sampleWrite <= !rd;
      sampleRead <= rd;
      repeat (n) @(posedge clk);
      sampleWrite <= 1'b0;
      sampleRead <= 1'b0;
   endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
   import abs_pkg::*;
   logic clk, rst, awV, wV, bR, arV, rR, awRdy, wRdy, bV, arRdy, rV, irq1, irq2, sW, sR;
   logic [31:0] awA, wD, arA, rD, got;
   logic [1:0] bRsp, rRsp, rsp;
   int errors, checks_done, cyc = 0;
   abs_status_flags uut (.clk(clk), .rst(rst), .sampleWrite(sW), .sampleRead(sR), .irqPinOne(irq1),
      .irqPinTwo(irq2), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bRsp), .s_axi_bvalid(bV),
      .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD),
      .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rR));
   abs_sample_src src (.clk(clk), .sampleWrite(sW), .sampleRead(sR));
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors = errors + 1;
         final_report;
      end
   end
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Bus cycles: address and data together, each released when taken
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge clk);
      awA <= {22'h0, a};
      wD <= {24'h0, d};
      {awV, wV, bR} <= 3'h7;
      while (pa | pw)
      begin
         @(posedge clk);
         pa = pa & !awRdy;
         pw = pw & !wRdy;
         awV <= pa;
         wV <= pw;
      end
      do @(posedge clk); while (bV !== 1'b1);
      rsp = bRsp;
      bR <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a);
      @(posedge clk);
      arA <= {22'h0, a};
      {arV, rR} <= 2'h3;
      do @(posedge clk); while (arRdy !== 1'b1);
      arV <= 1'b0;
      do @(posedge clk); while (rV !== 1'b1);
      got = rD;
      rsp = rRsp;
      rR <= 1'b0;
   endtask
   task automatic st(input logic [7:0] e);
      rd(ABS_ADDR_STATUS);
      chk(got, {24'h0, e});
      chk({30'h0, rsp}, {30'h0, ABS_RESP_OKAY});
   endtask
   // Scenarios
   task automatic t_off;
      st(8'h00);
      src.push(5, 1'b0);
      st(8'h00);
      $display("test off end");
   endtask
   task automatic t_fill;
      wr(ABS_ADDR_SETUP_ONE, 8'h01);
      chk({30'h0, rsp}, {30'h0, ABS_RESP_OKAY});
      wr(ABS_ADDR_SETUP_TWO, 8'h03);
      src.push(2, 1'b0);
      st(8'h02);
      src.push(1, 1'b0);
      st(8'h83);
      wr(ABS_ADDR_SETUP_IRQ, 8'h01);
      repeat (2) @(posedge clk);
      chk({30'h0, irq2, irq1}, 32'h1);
      wr(ABS_ADDR_SETUP_IRQ, 8'h03);
      repeat (2) @(posedge clk);
      chk({30'h0, irq2, irq1}, 32'h2);
      src.push(1, 1'b1);
      st(8'h02);
      $display("test fill end");
   endtask
   task automatic t_ovf;
      src.push(31, 1'b0);
      st(8'hE0);
      src.push(1, 1'b1);
      st(8'h9F);
      src.push(31, 1'b1);
      st(8'h00);
      $display("test overflow end");
   endtask
   task automatic t_flush;
      src.push(4, 1'b0);
      wr(ABS_ADDR_SETUP_TWO, 8'h83);
      st(8'h00);
      $display("test flush end");
   endtask
   task automatic t_dis;
      src.push(4, 1'b0);
      st(8'h84);
      wr(ABS_ADDR_SETUP_ONE, 8'h00);
      st(8'h00);
      wr(ABS_ADDR_SETUP_ONE, 8'h01);
      st(8'h00);
      $display("test disable end");
   endtask
   task automatic t_bad;
      wr(ABS_ADDR_STATUS, 8'h55);
      chk({30'h0, rsp}, {30'h0, ABS_RESP_SLVERR});
      rd(10'h3FC);
      chk({30'h0, rsp}, {30'h0, ABS_RESP_SLVERR});
      chk(got, 32'h0);
      $display("test refuse end");
   endtask
   task final_report;
      $display("Checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Reset for three clocks, then the scenarios
   initial
   begin
      {awV, wV, bR, arV, rR, rst} = 6'h01;
      {awA, wD, arA} = 96'h0;
      errors = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_off;
      t_fill;
      t_ovf;
      t_flush;
      t_dis;
      t_bad;
      final_report;
   end
endmodule
